// ---- bcs_sequencer.sv ----
// Charge-cycle sequencer with Avalon-MM register slave
// Summary of operation
// - New cycle starts only with temperature inside low-to-high start window.
// - Charging suspends outside low-to-cutoff window; resumes inside start window.
// - Suspend stops the power stage and freezes timers without clearing.
// - Below precharge exit level, apply precondition current and start its timer.
// - Precondition timeout stops charge, reports fault, applies replacement-sense current.
// - Precondition fault clears on reset, supply loss, battery replacement, enable fall or timer pin rise.
// - Cell input low selects 4.2 V regulation, high selects 8.4 V.
// - In constant-voltage phase, end the cycle at the taper cutoff current.
// - Recharge drop, power-on below recharge, enable toggle or timer pin restart charging.
// - Timer pin below enable level disables termination and the safety timer.
// - Timer pin rising above enable level re-enables both and zeroes the count.
// - Timer pin held high disables the safety and precondition timers, not termination.
// - Without adapter supply the sequencer sleeps.
// - Status A on in precondition and fast charge (off in suspend), B on when complete, both off otherwise.
// - Adapter-present output on once awake, off while asleep.
// - Charge only while the active-low enable is low.
// - Falling enable edge resets all timers and clears all faults.
// - Safety fault above recharge waits for a drop, then runs absence detection.
// - Safety fault below recharge applies replacement-sense current until battery rises.
// - Absence test: discharge then short check, wake then recharge check.
`include "bcs_consts.svh"

module bcs_sequencer #(
   parameter int unsigned DISCH_CYC = `BCS_DISCH_CYC,
   parameter int unsigned WAKE_CYC = `BCS_WAKE_CYC
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire bcs_pkg::bcs_sense_t sense,
   output bcs_pkg::bcs_drive_t drive
);
   import bcs_pkg::*;

   localparam bcs_regs_t RST = '{
      st: BCS_SLEEP,
      ce_n_p: 1'b1,
      safe_tc: `BCS_SAFE_TC_RST,
      pre_tc: `BCS_PRE_TC_RST,
      waitreq: 1'b1,
      drv: '{
         status_line_a_oe_n: 1'b1,
         status_line_b_oe_n: 1'b1,
         adapter_present_n_oe_n: 1'b1,
         default: 1'b0
      },
      default: '0
   };

   // Word index 0..4, 7 for an unmapped address
   function automatic logic [2:0] reg_index(input logic [4:0] a);
      case (a)
         `BCS_OFS_STATUS: reg_index = 3'h0;
         `BCS_OFS_SAFE_TC: reg_index = 3'h1;
         `BCS_OFS_PRE_TC: reg_index = 3'h2;
         `BCS_OFS_SAFE_CNT: reg_index = 3'h3;
         `BCS_OFS_PRE_CNT: reg_index = 3'h4;
         default: reg_index = 3'h7;
      endcase
   endfunction : reg_index

   function automatic logic [31:0] be_merge(
      input logic [31:0] old,
      input logic [31:0] nw,
      input logic [3:0] be
   );
      be_merge = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            be_merge[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
   endfunction : be_merge

   bcs_regs_t s_q;
   bcs_regs_t s_d;
   logic ce_fall;
   logic ttc_rise;
   logic timer_run;
   logic term_en;
   logic safe_to;
   logic pre_to;
   logic charging;
   logic [2:0] idx;

   always_comb begin
      s_d = s_q;
      ce_fall = s_q.ce_n_p && !sense.charge_en_n;
      ttc_rise = s_q.ttc_low_p && !sense.timer_cap_control_low;
      timer_run = !sense.timer_cap_control_low && !sense.timer_cap_control_high;
      term_en = !sense.timer_cap_control_low;
      safe_to = (s_q.st == BCS_FAST) && timer_run && (s_q.safe_cnt >= s_q.safe_tc);
      pre_to = (s_q.st == BCS_PRECOND) && timer_run && (s_q.pre_cnt >= s_q.pre_tc);
      s_d.ce_n_p = sense.charge_en_n;
      s_d.ttc_low_p = sense.timer_cap_control_low;

      case (s_q.st)
         BCS_SLEEP: begin
            if (sense.below_recharge) begin
               s_d.st = BCS_START;
            end else begin
               s_d.st = BCS_DONE;
            end
         end
         BCS_START: begin
            s_d.safe_cnt = '0;
            s_d.pre_cnt = '0;
            s_d.hi_seen = 1'b0;
            if (!sense.charge_en_n && sense.temp_start_ok) begin
               if (sense.below_precharge_exit) begin
                  s_d.st = BCS_PRECOND;
               end else begin
                  s_d.st = BCS_FAST;
               end
            end
         end
         BCS_PRECOND: begin
            if (pre_to) begin
               s_d.st = BCS_PRE_FLT;
            end else if (!sense.temp_run_ok) begin
               s_d.st = BCS_SUSP;
               s_d.ret_pre = 1'b1;
            end else if (!sense.below_precharge_exit) begin
               s_d.st = BCS_FAST;
            end else if (timer_run) begin
               s_d.pre_cnt = s_q.pre_cnt + 32'h0000_0001;
            end
         end
         BCS_FAST: begin
            if (safe_to) begin
               s_d.st = BCS_TMR_FLT;
               s_d.hi_seen = !sense.below_recharge;
            end else if (!sense.temp_run_ok) begin
               s_d.st = BCS_SUSP;
               s_d.ret_pre = 1'b0;
            end else if (term_en && sense.volt_reg_active && sense.taper_cutoff_current) begin
               s_d.st = BCS_DONE;
            end else if (timer_run) begin
               s_d.safe_cnt = s_q.safe_cnt + 32'h0000_0001;
            end
         end
         BCS_SUSP: begin
            // Counters are left untouched here
            if (sense.temp_start_ok) begin
               if (s_q.ret_pre) begin
                  s_d.st = BCS_PRECOND;
               end else begin
                  s_d.st = BCS_FAST;
               end
            end
         end
         BCS_DONE: begin
            if (sense.below_recharge) begin
               s_d.st = BCS_DET_DIS;
               s_d.det_cnt = '0;
            end
         end
         BCS_PRE_FLT: begin
            // A fresh pack lifts the battery above the exit level
            if (!sense.below_precharge_exit) begin
               s_d.st = BCS_START;
            end
         end
         BCS_TMR_FLT: begin
            if (!sense.below_recharge) begin
               s_d.hi_seen = 1'b1;
            end else if (s_q.hi_seen) begin
               s_d.st = BCS_DET_DIS;
               s_d.det_cnt = '0;
            end
         end
         BCS_DET_DIS: begin
            s_d.det_cnt = s_q.det_cnt + 32'h0000_0001;
            if (s_q.det_cnt >= 32'(DISCH_CYC - 1)) begin
               s_d.det_cnt = '0;
               if (sense.below_short) begin
                  s_d.st = BCS_DET_WAKE;
               end else begin
                  s_d.st = BCS_START;
               end
            end
         end
         BCS_DET_WAKE: begin
            s_d.det_cnt = s_q.det_cnt + 32'h0000_0001;
            if (s_q.det_cnt >= 32'(WAKE_CYC - 1)) begin
               s_d.det_cnt = '0;
               if (!sense.below_recharge) begin
                  s_d.st = BCS_ABSENT;
               end else begin
                  s_d.st = BCS_START;
               end
            end
         end
         BCS_ABSENT: begin
            if (sense.below_recharge) begin
               s_d.st = BCS_DET_DIS;
               s_d.det_cnt = '0;
            end
         end
         default: begin
            s_d.st = BCS_SLEEP;
         end
      endcase

      charging = (s_q.st == BCS_PRECOND) || (s_q.st == BCS_FAST) || (s_q.st == BCS_SUSP);
      if (!sense.wake_threshold) begin
         s_d.st = BCS_SLEEP;
      end else if ((ce_fall || ttc_rise) && !safe_to && !pre_to) begin
         // A timeout in the same cycle keeps its fault
         s_d.st = BCS_START;
         s_d.safe_cnt = '0;
         s_d.pre_cnt = '0;
         s_d.det_cnt = '0;
         s_d.hi_seen = 1'b0;
      end else if (sense.charge_en_n && charging) begin
         s_d.st = BCS_START;
      end

      s_d.drv.pwm_en = (s_d.st == BCS_PRECOND) || (s_d.st == BCS_FAST);
      s_d.drv.precondition_current_en = (s_d.st == BCS_PRECOND);
      s_d.drv.replacement_sense_current_en = (s_d.st == BCS_PRE_FLT) ||
         ((s_d.st == BCS_TMR_FLT) && !s_d.hi_seen);
      s_d.drv.discharge_en = (s_d.st == BCS_DET_DIS);
      s_d.drv.wake_en = (s_d.st == BCS_DET_WAKE);
      s_d.drv.regulation_voltage_8v4 = sense.cells_high;
      s_d.drv.status_line_a_o = 1'b0;
      s_d.drv.status_line_b_o = 1'b0;
      s_d.drv.adapter_present_n_o = 1'b0;
      s_d.drv.status_line_a_oe_n = !((s_d.st == BCS_PRECOND) || (s_d.st == BCS_FAST));
      s_d.drv.status_line_b_oe_n = (s_d.st != BCS_DONE);
      s_d.drv.adapter_present_n_oe_n = (s_d.st == BCS_SLEEP);

      // Bus slave: one wait cycle, then a single-cycle acknowledge
      idx = reg_index(avs_address);
      s_d.waitreq = 1'b1;
      if ((avs_read || avs_write) && s_q.waitreq) begin
         s_d.waitreq = 1'b0;
         case (idx)
            3'h0: begin
               s_d.rdata = '0;
               s_d.rdata[10:0] = s_q.st;
               s_d.rdata[`BCS_STAT_HI_BIT] = s_q.hi_seen;
               s_d.rdata[`BCS_STAT_RET_BIT] = s_q.ret_pre;
               s_d.rdata[`BCS_STAT_PIN_LSB +: 3] = {sense.adapter_present_n_i,
                  sense.status_line_b_i, sense.status_line_a_i};
            end
            3'h1: s_d.rdata = s_q.safe_tc;
            3'h2: s_d.rdata = s_q.pre_tc;
            3'h3: s_d.rdata = s_q.safe_cnt;
            3'h4: s_d.rdata = s_q.pre_cnt;
            default: s_d.rdata = '0;
         endcase
      end
      if (avs_write && !s_q.waitreq) begin
         if (idx == 3'h1) begin
            s_d.safe_tc = be_merge(s_q.safe_tc, avs_writedata, avs_byteenable);
         end else if (idx == 3'h2) begin
            s_d.pre_tc = be_merge(s_q.pre_tc, avs_writedata, avs_byteenable);
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_q <= RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign avs_readdata = s_q.rdata;
   assign avs_waitrequest = s_q.waitreq;
   assign drive = s_q.drv;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   sequence susp_hold_s;
      (s_q.st == BCS_SUSP) ##1 (s_q.st == BCS_SUSP);
   endsequence

   sequence dis_to_wake_s;
      (s_q.st == BCS_DET_DIS) ##1 (s_q.st == BCS_DET_WAKE);
   endsequence

   sequence wake_to_absent_s;
      (s_q.st == BCS_DET_WAKE) ##1 (s_q.st == BCS_ABSENT);
   endsequence

   a_start_temp_ok: assert property (
      (s_q.st == BCS_START) ##1 (s_q.st inside {BCS_PRECOND, BCS_FAST})
      |-> $past(sense.temp_start_ok))
      else $error("charge began outside temperature start window");

   a_susp_cause: assert property (
      $rose(s_q.st == BCS_SUSP) |-> $past(!sense.temp_run_ok))
      else $error("suspend entered with temperature in window");

   a_susp_freeze: assert property (
      susp_hold_s |-> $stable(s_q.safe_cnt) && $stable(s_q.pre_cnt) && !drive.pwm_en)
      else $error("timer moved or power stage on during suspend");

   a_pre_fault_out: assert property (
      (s_q.st == BCS_PRE_FLT) |-> drive.replacement_sense_current_en && !drive.pwm_en
      && drive.status_line_a_oe_n && drive.status_line_b_oe_n)
      else $error("precondition fault outputs wrong");

   a_cells_follow: assert property (
      sense.cells_high |=> drive.regulation_voltage_8v4)
      else $error("two-cell select not applied");

   a_ttc_low_hold: assert property (
      (s_q.st == BCS_FAST) && sense.timer_cap_control_low ##1 (s_q.st == BCS_FAST)
      |-> $stable(s_q.safe_cnt))
      else $error("safety timer ran with timer pin low");

   a_ttc_rise_zero: assert property (
      $fell(sense.timer_cap_control_low) && sense.wake_threshold && !safe_to && !pre_to
      |=> s_q.safe_cnt == 32'h0000_0000 && s_q.st == BCS_START)
      else $error("timer pin rise did not restart count");

   a_sleep_pg_off: assert property (
      !sense.wake_threshold |=> (s_q.st == BCS_SLEEP) && drive.adapter_present_n_oe_n
      && drive.status_line_a_oe_n && drive.status_line_b_oe_n)
      else $error("not asleep without supply");

   a_done_status: assert property (
      (s_q.st == BCS_DONE) |-> drive.status_line_a_oe_n && !drive.status_line_b_oe_n)
      else $error("complete status wrong");

   a_enable_inhibit: assert property (
      sense.charge_en_n ##1 sense.charge_en_n |=> !drive.pwm_en)
      else $error("charging while enable high");

   a_ce_fall_clear: assert property (
      $fell(sense.charge_en_n) && sense.wake_threshold && !safe_to && !pre_to
      |=> s_q.st == BCS_START ##1 s_q.safe_cnt == 32'h0000_0000)
      else $error("enable edge did not clear timers");

   a_det_short: assert property (
      dis_to_wake_s |-> $past(sense.below_short) && drive.wake_en)
      else $error("wake test entered without short check");

   a_det_absent: assert property (
      wake_to_absent_s |-> $past(!sense.below_recharge) && drive.status_line_a_oe_n)
      else $error("absent flagged without recharge check");

   a_bus_ack_once: assert property (
      !avs_waitrequest |=> avs_waitrequest)
      else $error("acknowledge longer than one cycle");

   a_cells_low: assert property (
      !sense.cells_high |=> !drive.regulation_voltage_8v4)
      else $error("one-cell select not applied");

   a_charge_status: assert property (
      (s_q.st == BCS_FAST) |-> !drive.status_line_a_oe_n && drive.status_line_b_oe_n)
      else $error("charge status wrong");

   a_tmr_flt_sense: assert property (
      (s_q.st == BCS_TMR_FLT) && !s_q.hi_seen |-> drive.replacement_sense_current_en
      && !drive.pwm_en)
      else $error("timer fault without replacement-sense current");

endmodule : bcs_sequencer

// ---- bcs_consts.svh ----
// Offsets, reset values and timing counts of the charge sequencer
`ifndef BCS_CONSTS_SVH
`define BCS_CONSTS_SVH

`define BCS_CLK_KHZ 10000
`define BCS_DISCH_MS 1000
`define BCS_WAKE_MS 500
`define BCS_DISCH_CYC (`BCS_DISCH_MS * `BCS_CLK_KHZ)
`define BCS_WAKE_CYC (`BCS_WAKE_MS * `BCS_CLK_KHZ)

`define BCS_OFS_STATUS 5'h00
`define BCS_OFS_SAFE_TC 5'h04
`define BCS_OFS_PRE_TC 5'h08
`define BCS_OFS_SAFE_CNT 5'h0C
`define BCS_OFS_PRE_CNT 5'h10

`define BCS_SAFE_TC_RST 32'h0100_0000
`define BCS_PRE_TC_RST 32'h0010_0000

`define BCS_STAT_HI_BIT 11
`define BCS_STAT_RET_BIT 12
`define BCS_STAT_PIN_LSB 16

`endif

// ---- bcs_pkg.sv ----
// Types shared by the charge sequencer
package bcs_pkg;

   typedef enum logic [10:0] {
      BCS_SLEEP = 11'h001,
      BCS_START = 11'h002,
      BCS_PRECOND = 11'h004,
      BCS_FAST = 11'h008,
      BCS_SUSP = 11'h010,
      BCS_DONE = 11'h020,
      BCS_PRE_FLT = 11'h040,
      BCS_TMR_FLT = 11'h080,
      BCS_DET_DIS = 11'h100,
      BCS_DET_WAKE = 11'h200,
      BCS_ABSENT = 11'h400
   } bcs_state_t;

   // Comparator results and pin levels
   typedef struct packed {
      logic wake_threshold;
      logic charge_en_n;
      logic temp_start_ok;
      logic temp_run_ok;
      logic below_precharge_exit;
      logic below_recharge;
      logic below_short;
      logic volt_reg_active;
      logic taper_cutoff_current;
      logic timer_cap_control_low;
      logic timer_cap_control_high;
      logic cells_high;
      logic status_line_a_i;
      logic status_line_b_i;
      logic adapter_present_n_i;
   } bcs_sense_t;

   // Power stage controls and open-drain pins
   typedef struct packed {
      logic pwm_en;
      logic precondition_current_en;
      logic replacement_sense_current_en;
      logic discharge_en;
      logic wake_en;
      logic regulation_voltage_8v4;
      logic status_line_a_o;
      logic status_line_a_oe_n;
      logic status_line_b_o;
      logic status_line_b_oe_n;
      logic adapter_present_n_o;
      logic adapter_present_n_oe_n;
   } bcs_drive_t;

   typedef struct packed {
      bcs_state_t st;
      logic ret_pre;
      logic hi_seen;
      logic ce_n_p;
      logic ttc_low_p;
      logic [31:0] safe_cnt;
      logic [31:0] pre_cnt;
      logic [31:0] det_cnt;
      logic [31:0] safe_tc;
      logic [31:0] pre_tc;
      logic waitreq;
      logic [31:0] rdata;
      bcs_drive_t drv;
   } bcs_regs_t;

endpackage : bcs_pkg

// ---- bcs_pack_model.sv ----
// Battery pack with thermistor plus pulled-up status lines facing the sequencer
module bcs_pack_model (
   input wire bcs_pkg::bcs_sense_t knobs,
   input wire bcs_pkg::bcs_drive_t drive,
   output bcs_pkg::bcs_sense_t sense
);
   import bcs_pkg::*;
   always_comb begin
      sense = knobs;
      // Released open-drain lines float high through their pull-ups
      sense.status_line_a_i = drive.status_line_a_oe_n ? 1'b1 : drive.status_line_a_o;
      sense.status_line_b_i = drive.status_line_b_oe_n ? 1'b1 : drive.status_line_b_o;
      sense.adapter_present_n_i = drive.adapter_present_n_oe_n ? 1'b1 :
         drive.adapter_present_n_o;
   end
endmodule : bcs_pack_model

// ---- bcs_tb.sv ----
// Self-checking bench for the charge sequencer
`include "bcs_consts.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import bcs_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [3:0] avs_byteenable = 4'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [31:0] rd;
   logic [31:0] cnt;
   bcs_sense_t kn;
   bcs_sense_t sense;
   bcs_drive_t drive;
   int fail_count = 0;
   int checked = 0;

   bcs_sequencer #(.DISCH_CYC(8), .WAKE_CYC(4)) bcs_sequencer_i (.clk(clk), .sys_rst(sys_rst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .sense(sense), .drive(drive));
   bcs_pack_model bcs_pack_model_i (.knobs(kn), .drive(drive), .sense(sense));

   initial begin
      forever #50 clk = ~clk;
   end

   task automatic print_verdict;
      $display("Comparisons %0d, mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : print_verdict

   task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp32

   task automatic cmp1(input logic got, input logic exp);
      cmp32({31'h0, got}, {31'h0, exp});
   endtask : cmp1

   task automatic go(input int n);
      repeat (n) @(posedge clk);
   endtask : go

   // One Avalon transfer; request held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
      input logic [3:0] be);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_read <= !w;
      avs_write <= w;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
      // The slave inserts exactly one wait cycle
      cmp32(n, 32'h0000_0002);
   endtask : bus

   task automatic rdr(input logic [4:0] a);
      bus(1'b0, a, 32'h0000_0000, 4'h0);
   endtask : rdr

   // Polls the state field until it matches or the poll budget runs out
   task automatic exp_st(input bcs_state_t s, input int lim);
      int n;
      n = 0;
      do begin
         rdr(`BCS_OFS_STATUS);
         n++;
      end while (rd[10:0] !== s && n < lim);
      cmp32({21'h0, rd[10:0]}, {21'h0, s});
   endtask : exp_st

   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      print_verdict();
   end

   initial begin
      kn = '0;
      kn.wake_threshold = 1'b1;
      kn.charge_en_n = 1'b1;
      kn.temp_run_ok = 1'b1;
      kn.below_recharge = 1'b1;
      kn.below_precharge_exit = 1'b1;
      repeat (20) @(posedge clk);
      cmp1(drive.adapter_present_n_oe_n, 1'b1);
      sys_rst <= 1'b0;
      go(3);
      cmp1(drive.adapter_present_n_oe_n, 1'b0);
      exp_st(BCS_START, 1);
      rdr(`BCS_OFS_SAFE_TC);
      cmp32(rd, 32'h0100_0000);
      bus(1'b1, `BCS_OFS_PRE_TC, 32'hffff_ff14, 4'h1);
      rdr(`BCS_OFS_PRE_TC);
      cmp32(rd, 32'h0010_0014);
      bus(1'b1, 5'h14, 32'h1234_5678, 4'hf);
      rdr(5'h14);
      cmp32(rd, 32'h0000_0000);
      bus(1'b1, `BCS_OFS_PRE_TC, 32'h0000_0014, 4'hf);
      bus(1'b1, `BCS_OFS_SAFE_TC, 32'h0000_0028, 4'hf);
      rdr(`BCS_OFS_SAFE_TC);
      cmp32(rd, 32'h0000_0028);
      $display("Test registers done");
      kn.charge_en_n <= 1'b0;
      exp_st(BCS_START, 1);
      cmp1(drive.pwm_en, 1'b0);
      kn.temp_start_ok <= 1'b1;
      exp_st(BCS_PRECOND, 3);
      cmp1(drive.precondition_current_en, 1'b1);
      cmp1(drive.status_line_a_oe_n, 1'b0);
      cmp1(drive.status_line_b_oe_n, 1'b1);
      kn.temp_run_ok <= 1'b0;
      kn.temp_start_ok <= 1'b0;
      exp_st(BCS_SUSP, 2);
      cmp1(drive.pwm_en, 1'b0);
      cmp1(drive.status_line_a_oe_n, 1'b1);
      rdr(`BCS_OFS_PRE_CNT);
      cnt = rd;
      go(10);
      rdr(`BCS_OFS_PRE_CNT);
      cmp32(rd, cnt);
      kn.temp_run_ok <= 1'b1;
      go(3);
      exp_st(BCS_SUSP, 1);
      cmp1(rd[`BCS_STAT_RET_BIT], 1'b1);
      kn.temp_start_ok <= 1'b1;
      exp_st(BCS_PRECOND, 3);
      $display("Test suspend done");
      exp_st(BCS_PRE_FLT, 20);
      cmp1(drive.pwm_en, 1'b0);
      cmp1(drive.replacement_sense_current_en, 1'b1);
      cmp1(drive.status_line_a_oe_n & drive.status_line_b_oe_n, 1'b1);
      kn.below_recharge <= 1'b0;
      go(5);
      exp_st(BCS_PRE_FLT, 1);
      kn.below_precharge_exit <= 1'b0;
      exp_st(BCS_FAST, 5);
      $display("Test precondition done");
      kn.timer_cap_control_low <= 1'b1;
      kn.volt_reg_active <= 1'b1;
      kn.taper_cutoff_current <= 1'b1;
      go(60);
      exp_st(BCS_FAST, 1);
      kn.cells_high <= 1'b1;
      go(2);
      cmp1(drive.regulation_voltage_8v4, 1'b1);
      kn.cells_high <= 1'b0;
      go(2);
      cmp1(drive.regulation_voltage_8v4, 1'b0);
      kn.taper_cutoff_current <= 1'b0;
      kn.timer_cap_control_high <= 1'b1;
      kn.timer_cap_control_low <= 1'b0;
      go(2);
      rdr(`BCS_OFS_SAFE_CNT);
      cmp32(rd, 32'h0000_0000);
      go(60);
      exp_st(BCS_FAST, 1);
      kn.taper_cutoff_current <= 1'b1;
      exp_st(BCS_DONE, 3);
      cmp32({29'h0, rd[`BCS_STAT_PIN_LSB +: 3]}, 32'h0000_0001);
      cmp1(drive.status_line_b_oe_n, 1'b0);
      cmp1(drive.status_line_a_oe_n, 1'b1);
      $display("Test timer pin done");
      kn.below_short <= 1'b1;
      kn.below_recharge <= 1'b1;
      exp_st(BCS_DET_DIS, 2);
      cmp1(drive.discharge_en, 1'b1);
      kn.below_recharge <= 1'b0;
      exp_st(BCS_ABSENT, 10);
      cmp1(drive.status_line_a_oe_n & drive.status_line_b_oe_n, 1'b1);
      kn.below_short <= 1'b0;
      kn.taper_cutoff_current <= 1'b0;
      kn.below_recharge <= 1'b1;
      exp_st(BCS_FAST, 20);
      $display("Test absence done");
      kn.timer_cap_control_high <= 1'b0;
      exp_st(BCS_TMR_FLT, 30);
      cmp1(drive.pwm_en, 1'b0);
      cmp1(drive.replacement_sense_current_en, 1'b1);
      kn.below_recharge <= 1'b0;
      go(2);
      cmp1(drive.replacement_sense_current_en, 1'b0);
      exp_st(BCS_TMR_FLT, 1);
      cmp1(rd[`BCS_STAT_HI_BIT], 1'b1);
      kn.below_recharge <= 1'b1;
      exp_st(BCS_DET_DIS, 2);
      exp_st(BCS_FAST, 10);
      exp_st(BCS_TMR_FLT, 30);
      kn.charge_en_n <= 1'b1;
      exp_st(BCS_TMR_FLT, 2);
      cmp1(drive.pwm_en, 1'b0);
      kn.charge_en_n <= 1'b0;
      exp_st(BCS_FAST, 3);
      rdr(`BCS_OFS_SAFE_CNT);
      cmp1(rd < 32'h0000_0010, 1'b1);
      kn.charge_en_n <= 1'b1;
      exp_st(BCS_START, 2);
      cmp1(drive.pwm_en, 1'b0);
      $display("Test timer fault done");
      kn.wake_threshold <= 1'b0;
      exp_st(BCS_SLEEP, 2);
      cmp1(drive.pwm_en, 1'b0);
      cmp1(drive.adapter_present_n_oe_n, 1'b1);
      cmp1(drive.status_line_a_oe_n & drive.status_line_b_oe_n, 1'b1);
      $display("Test sleep done");
      print_verdict();
   end
endmodule : tb
